// ### adc_seq_map.vh
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// Conversion lengths in converter clock cycles.
`define CONV_CYCLES_NORMAL 5'd13
`define CONV_CYCLES_FIRST 5'd25
// Sample instants in converter half cycles from conversion start.
`define SAMPLE_HALF_NORMAL 6'd3
`define SAMPLE_HALF_FIRST 6'd27
`define SAMPLE_HALF_AUTO 6'd4
`define SAMPLE_HALF_FREE 6'd5
// Result layout.
`define RESULT_BITS 10
`define RESULT_MAX 10'h03FF
// Channel encoding: 0..7 external pins, then internal sources.
`define CHAN_TEMP 4'h8
`define CHAN_BANDGAP 4'hE
`define CHAN_GROUND 4'hF
// Trigger source of the converter's own completion flag.
`define TRIG_SRC_DONE 3'h0
// Reference select values.
`define REF_SUPPLY 1'b0
`define REF_INTERNAL 1'b1

`endif

// ### adc_prescaler.v
`timescale 1ns/1ns
`default_nettype none

module adc_prescaler (
    // Clock and reset.
    input wire sys_clk_i,
    input wire nrst_i,
    // Control.
    input wire run_i,
    input wire restart_i,
    input wire [2:0] clock_prescale_select_i,
    // Converter clock edges, one cycle pulses.
    output reg rise_o,
    output reg fall_o
);
    reg [6:0] count;
    reg [6:0] half;

    always @* begin
        case (clock_prescale_select_i)
            3'h0, 3'h1: half = 7'h01;
            3'h2: half = 7'h02;
            3'h3: half = 7'h04;
            3'h4: half = 7'h08;
            3'h5: half = 7'h10;
            3'h6: half = 7'h20;
            default: half = 7'h40;
        endcase
    end

    // Held in reset while disabled, so the first edge has a fixed phase.
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= 7'h00;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else if (!run_i || restart_i) begin
            count <= 7'h00;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= (count == (half + half - 7'h01));
            fall_o <= (count == (half - 7'h01));
            if (count == (half + half - 7'h01)) begin
                count <= 7'h00;
            end else begin
                count <= count + 7'h01;
            end
        end
    end
endmodule

`default_nettype wire

// ### adc_sequencer.v
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_map.vh"

// Functional notes
// - Produce a 10-bit result by successive approximation, ground to reference.
// - One bit chooses supply or internal 1.1V reference.
// - Reference and channel reach the converter only while enabled.
// - Result right-aligned by default, left-aligned when left adjust set.
// - Reading low byte blocks updates until high byte read; results lost.
// - Completion flag is raised even when the result was discarded.
// - Start bit stays high while converting, cleared by hardware at end.
// - Channel change mid-conversion applies after the current conversion.
// - Auto trigger rising edge resets prescaler and starts a conversion.
// - Held-high trigger or edges during conversion start nothing.
// - Flags set regardless of enables; software clears trigger flag.
// - With done flag as trigger, conversions chain; first by start bit.
// - Start bit works with auto trigger and reads one while converting.
// - Prescaler counts from enable and is held reset while disabled.
// - Start-bit conversion begins on next rising converter clock edge.
// - Normal conversion 13 cycles, first after enabling 25 cycles.
// - Sample at 1.5 cycles normally, 13.5 on first conversion.
// - At completion write result, set flag, clear start bit together.
// - Auto-triggered sample two cycles after the first rising edge following the trigger edge.
// - Free running restarts at once; sample at 2.5 cycles.
// - Selections track writes, freeze in conversion, resume last cycle.
module adc_sequencer #(
    parameter PRESCALE_BITS = 3,
    parameter TRIG_SOURCES = 8
) (
    // Clock and reset.
    input wire sys_clk_i,
    input wire nrst_i,
    // Control bits.
    input wire converter_power_reduction_i,
    input wire converter_enable_i,
    input wire start_conversion_write_i,
    input wire auto_trigger_enable_i,
    input wire [2:0] trigger_source_select_i,
    input wire [TRIG_SOURCES-1:0] trigger_sources_i,
    input wire left_adjust_result_i,
    input wire reference_select_i,
    input wire [3:0] channel_select_i,
    input wire [PRESCALE_BITS-1:0] clock_prescale_select_i,
    input wire done_flag_clear_i,
    // Result byte read strobes.
    input wire result_low_read_i,
    input wire result_high_read_i,
    // Analog core.
    input wire comparator_i,
    output reg [3:0] mux_channel_o,
    output reg reference_internal_o,
    output reg analog_enable_o,
    output reg sample_hold_o,
    output reg [`RESULT_BITS-1:0] dac_code_o,
    // Status.
    output reg start_conversion_bit_o,
    output reg conversion_done_flag_o,
    output reg [7:0] result_high_byte_o,
    output reg [7:0] result_low_byte_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_CONV = 4'b0100;
    localparam ST_DONE = 4'b1000;

    reg [3:0] state;
    reg [5:0] half_cnt;
    reg [5:0] sample_at;
    reg [4:0] conv_len;
    reg first_pending;
    reg lock_results;
    reg trig_prev;
    reg [`RESULT_BITS-1:0] sar;
    reg [3:0] bit_idx;
    reg [3:0] chan_buf;
    reg ref_buf;
    reg sampled;
    reg auto_start;
    reg done_prev;

    wire enabled = converter_enable_i && !converter_power_reduction_i;
    wire adc_rise;
    wire adc_fall;
    wire trig_sel;
    wire trig_edge;
    wire restart;
    wire finishing;
    wire [15:0] aligned;

    // Completion flag as source is taken from our own flag output, which stays set until cleared.
    assign trig_sel = (trigger_source_select_i == `TRIG_SRC_DONE) ? conversion_done_flag_o
                      : trigger_sources_i[trigger_source_select_i];
    assign trig_edge = auto_trigger_enable_i && trig_sel && !trig_prev;
    assign restart = trig_edge && (state == ST_IDLE);
    assign finishing = (state == ST_CONV) && adc_rise && (half_cnt + 6'd1 >= {conv_len, 1'b0});

    adc_prescaler u_prescaler (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .run_i(enabled),
        .restart_i(restart),
        .clock_prescale_select_i(clock_prescale_select_i),
        .rise_o(adc_rise),
        .fall_o(adc_fall)
    );

    function [15:0] align;
        input [`RESULT_BITS-1:0] value;
        input left;
        begin
            if (left) begin
                align = {value, 6'h00};
            end else begin
                align = {6'h00, value};
            end
        end
    endfunction

    // One approximation step: settle the bit under trial and raise the next one.
    function [`RESULT_BITS-1:0] sar_step;
        input [`RESULT_BITS-1:0] value;
        input [3:0] idx;
        input keep;
        reg [`RESULT_BITS-1:0] next_code;
        begin
            next_code = value;
            if (!keep) begin
                next_code[idx] = 1'b0;
            end
            if (idx != 4'd0) begin
                next_code[idx - 4'd1] = 1'b1;
            end
            sar_step = next_code;
        end
    endfunction

    assign aligned = align(sar, left_adjust_result_i);

    ////////////////////////////////////////////////////////////////////////////
    // Selection buffer: tracks writes except while a conversion holds it.

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chan_buf <= 4'h0;
            ref_buf <= `REF_SUPPLY;
            mux_channel_o <= `CHAN_GROUND;
            reference_internal_o <= 1'b0;
            analog_enable_o <= 1'b0;
        end else begin
            if (state == ST_IDLE || state == ST_WAIT || half_cnt + 6'd2 >= {conv_len, 1'b0}) begin
                chan_buf <= channel_select_i;
                ref_buf <= reference_select_i;
            end
            analog_enable_o <= enabled;
            // Unmapped codes fall back to ground.
            if (!enabled) begin
                mux_channel_o <= `CHAN_GROUND;
                reference_internal_o <= 1'b0;
            end else begin
                if (chan_buf <= `CHAN_TEMP || chan_buf == `CHAN_BANDGAP) begin
                    mux_channel_o <= chan_buf;
                end else begin
                    mux_channel_o <= `CHAN_GROUND;
                end
                reference_internal_o <= (ref_buf == `REF_INTERNAL);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
            half_cnt <= 6'd0;
            sample_at <= `SAMPLE_HALF_NORMAL;
            conv_len <= `CONV_CYCLES_NORMAL;
            first_pending <= 1'b1;
            trig_prev <= 1'b0;
            sar <= 10'h000;
            bit_idx <= 4'd0;
            sampled <= 1'b0;
            auto_start <= 1'b0;
            done_prev <= 1'b0;
            sample_hold_o <= 1'b0;
            dac_code_o <= 10'h000;
            start_conversion_bit_o <= 1'b0;
        end else begin
            trig_prev <= trig_sel;
            if (!enabled) begin
                state <= ST_IDLE;
                first_pending <= 1'b1;
                start_conversion_bit_o <= 1'b0;
                sample_hold_o <= 1'b0;
                half_cnt <= 6'd0;
                done_prev <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (restart) begin
                            start_conversion_bit_o <= 1'b1;
                            auto_start <= 1'b1;
                            state <= ST_WAIT;
                        end else if (start_conversion_write_i) begin
                            start_conversion_bit_o <= 1'b1;
                            auto_start <= 1'b0;
                            state <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (adc_rise) begin
                            state <= ST_CONV;
                            half_cnt <= 6'd0;
                            sampled <= 1'b0;
                            sar <= 10'h200;
                            bit_idx <= 4'd9;
                            conv_len <= first_pending ? `CONV_CYCLES_FIRST : `CONV_CYCLES_NORMAL;
                            if (first_pending) begin
                                sample_at <= `SAMPLE_HALF_FIRST;
                            end else if (auto_start) begin
                                sample_at <= `SAMPLE_HALF_AUTO;
                            end else if (done_prev) begin
                                sample_at <= `SAMPLE_HALF_FREE;
                            end else begin
                                sample_at <= `SAMPLE_HALF_NORMAL;
                            end
                            first_pending <= 1'b0;
                            // Held until the start so a slow converter clock still sees the chain.
                            done_prev <= 1'b0;
                        end
                    end
                    ST_CONV: begin
                        if (adc_rise || adc_fall) begin
                            half_cnt <= half_cnt + 6'd1;
                        end
                        sample_hold_o <= (half_cnt < sample_at);
                        // The auto-trigger sample point falls on a rising edge, the others on falling ones.
                        if ((adc_rise || adc_fall) && half_cnt + 6'd1 == sample_at) begin
                            sampled <= 1'b1;
                            dac_code_o <= sar;
                        end
                        // One approximation step per rising edge once held.
                        if (sampled && adc_rise && !finishing) begin
                            // The DAC shows the new trial at once; a stale code would judge each bit a step late.
                            sar <= sar_step(sar, bit_idx, comparator_i);
                            dac_code_o <= sar_step(sar, bit_idx, comparator_i);
                            if (bit_idx != 4'd0) begin
                                bit_idx <= bit_idx - 4'd1;
                            end
                        end
                        if (finishing) begin
                            state <= ST_DONE;
                        end
                    end
                    default: begin
                        sample_hold_o <= 1'b0;
                        // Chain when our own flag is the selected trigger.
                        if (auto_trigger_enable_i && trigger_source_select_i == `TRIG_SRC_DONE) begin
                            state <= ST_WAIT;
                            done_prev <= 1'b1;
                            auto_start <= 1'b0;
                        end else begin
                            start_conversion_bit_o <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result registers, read lock and completion flag.

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lock_results <= 1'b0;
            result_high_byte_o <= 8'h00;
            result_low_byte_o <= 8'h00;
            conversion_done_flag_o <= 1'b0;
        end else begin
            if (result_high_read_i) begin
                lock_results <= 1'b0;
            end else if (result_low_read_i) begin
                lock_results <= 1'b1;
            end
            if (state == ST_DONE) begin
                // Set wins over a clear in the same cycle.
                conversion_done_flag_o <= 1'b1;
                if (!lock_results || result_high_read_i) begin
                    result_high_byte_o <= aligned[15:8];
                    result_low_byte_o <= aligned[7:0];
                end
            end else if (done_flag_clear_i) begin
                conversion_done_flag_o <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ### adc_sequencer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_properties #(
    parameter TRIG_SOURCES = 8
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Control inputs.
    input wire logic converter_power_reduction_i,
    input wire logic converter_enable_i,
    input wire logic start_conversion_write_i,
    input wire logic auto_trigger_enable_i,
    input wire logic [2:0] trigger_source_select_i,
    input wire logic [TRIG_SOURCES-1:0] trigger_sources_i,
    input wire logic left_adjust_result_i,
    input wire logic result_low_read_i,
    input wire logic result_high_read_i,
    // Observed outputs.
    input wire logic analog_enable_o,
    input wire logic sample_hold_o,
    input wire logic start_conversion_bit_o,
    input wire logic conversion_done_flag_o,
    input wire logic [7:0] result_high_byte_o,
    input wire logic [7:0] result_low_byte_o
);
    logic locked;
    logic [7:0] busy_cnt;
    wire enabled = converter_enable_i && !converter_power_reduction_i;
    // The busy counter saturates so that a long free-running stretch cannot wrap into a short one.
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            locked <= 1'b0;
            busy_cnt <= 8'h00;
        end else begin
            if (result_low_read_i) begin
                locked <= 1'b1;
            end else if (result_high_read_i) begin
                locked <= 1'b0;
            end
            busy_cnt <= !start_conversion_bit_o ? 8'h00 : (busy_cnt == 8'hFF ? busy_cnt : busy_cnt + 8'h01);
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_START_ACCEPT: assert property (start_conversion_write_i && enabled && !start_conversion_bit_o
        |=> start_conversion_bit_o) else $error("start write not accepted");
    AST_END_SETS_FLAG: assert property ($fell(start_conversion_bit_o) && enabled && $past(enabled)
        |-> conversion_done_flag_o) else $error("flag not set at completion");
    AST_RESULT_LOCKED: assert property (locked && !result_high_read_i
        |=> $stable({result_high_byte_o, result_low_byte_o})) else $error("result changed while locked");
    AST_RIGHT_ALIGN: assert property (!$stable({result_high_byte_o, result_low_byte_o}) && !$past(left_adjust_result_i)
        |-> result_high_byte_o[7:2] == 6'h00) else $error("right aligned result has high bits");
    AST_LEFT_ALIGN: assert property (!$stable({result_high_byte_o, result_low_byte_o}) && $past(left_adjust_result_i)
        |-> result_low_byte_o[5:0] == 6'h00) else $error("left aligned result has low bits");
    AST_MIN_LENGTH: assert property ($fell(start_conversion_bit_o) && enabled && $past(enabled)
        |-> busy_cnt >= 8'd24) else $error("conversion too short");
    AST_SAMPLE_IN_CONV: assert property ($rose(start_conversion_bit_o)
        |-> ##[1:300] sample_hold_o) else $error("no sampling phase in conversion");
    AST_TRIGGER_START: assert property (enabled && auto_trigger_enable_i && trigger_source_select_i != 3'h0
        && !start_conversion_bit_o && $rose(trigger_sources_i[trigger_source_select_i])
        |-> ##[1:5] start_conversion_bit_o) else $error("trigger edge started nothing");
    AST_DISABLED_OFF: assert property (!enabled
        |=> !analog_enable_o && !start_conversion_bit_o) else $error("disabled converter active");
endmodule
bind adc_sequencer adc_sequencer_properties #(.TRIG_SOURCES(TRIG_SOURCES)) u_props (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .converter_power_reduction_i(converter_power_reduction_i),
    .converter_enable_i(converter_enable_i), .start_conversion_write_i(start_conversion_write_i),
    .auto_trigger_enable_i(auto_trigger_enable_i), .trigger_source_select_i(trigger_source_select_i),
    .trigger_sources_i(trigger_sources_i), .left_adjust_result_i(left_adjust_result_i),
    .result_low_read_i(result_low_read_i), .result_high_read_i(result_high_read_i),
    .analog_enable_o(analog_enable_o), .sample_hold_o(sample_hold_o),
    .start_conversion_bit_o(start_conversion_bit_o), .conversion_done_flag_o(conversion_done_flag_o),
    .result_high_byte_o(result_high_byte_o), .result_low_byte_o(result_low_byte_o)
);
`default_nettype wire

// ### analog_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module analog_core_model (
    // Clock.
    input wire logic sys_clk_i,
    // Converter side.
    input wire logic [3:0] mux_channel_i,
    input wire logic reference_internal_i,
    input wire logic analog_enable_i,
    input wire logic sample_hold_i,
    input wire logic [9:0] dac_code_i,
    // Comparator result.
    output logic comparator_o
);
    logic [9:0] held = 10'h000;
    logic wiggle = 1'b0;
    function automatic logic [9:0] level(input logic [3:0] ch, input logic r);
        level = (ch == 4'hF) ? 10'h000 : (r ? {1'b0, ch, 5'h0A} : {ch, 6'h15});
    endfunction
    always @(posedge sys_clk_i) begin
        wiggle <= ~wiggle;
        if (sample_hold_i && analog_enable_i) begin
            held <= level(mux_channel_i, reference_internal_i);
        end
    end
    // Half an LSB above the code, so either strictness of comparison gives the same result.
    // An unpowered core toggles instead of resting at a level the sequencer might happen to like.
    assign comparator_o = analog_enable_i ? ({held, 1'b1} > {dac_code_i, 1'b0}) : wiggle;
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic pwr_off = 1'b0, en = 1'b0, st_wr = 1'b0, auto_en = 1'b0, left = 1'b0, rsel = 1'b0;
    logic clr = 1'b0, lo_rd = 1'b0, hi_rd = 1'b0, cmp, ref_int, ana_en, sh, st_bit, flag;
    logic [2:0] tsel = 3'h0, psel = 3'h0;
    logic [7:0] trig = 8'h00, r_hi, r_lo;
    logic [3:0] chan = 4'h0, channel_select, ch;
    logic [9:0] dac;
    int mismatches = 0, comparisons = 0, cycles = 0, busy = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    adc_sequencer DUT (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .converter_power_reduction_i(pwr_off),
        .converter_enable_i(en), .start_conversion_write_i(st_wr), .auto_trigger_enable_i(auto_en),
        .trigger_source_select_i(tsel), .trigger_sources_i(trig), .left_adjust_result_i(left),
        .reference_select_i(rsel), .channel_select_i(chan), .clock_prescale_select_i(psel),
        .done_flag_clear_i(clr), .result_low_read_i(lo_rd), .result_high_read_i(hi_rd),
        .comparator_i(cmp), .mux_channel_o(channel_select), .reference_internal_o(ref_int), .analog_enable_o(ana_en),
        .sample_hold_o(sh), .dac_code_o(dac), .start_conversion_bit_o(st_bit),
        .conversion_done_flag_o(flag), .result_high_byte_o(r_hi), .result_low_byte_o(r_lo)
    );
    analog_core_model core (
        .sys_clk_i(sys_clk_i), .mux_channel_i(channel_select), .reference_internal_i(ref_int),
        .analog_enable_i(ana_en), .sample_hold_i(sh), .dac_code_i(dac), .comparator_o(cmp)
    );
    ////////////////////////////////////////
    function automatic logic [15:0] word(input logic [3:0] c, input logic r, input logic l);
        logic [9:0] v;
        v = (c == 4'hF) ? 10'h000 : (r ? {1'b0, c, 5'h0A} : {c, 6'h15});
        word = l ? {v, 6'h00} : {6'h00, v};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_idle();
        busy = 7;
        while (st_bit !== 1'b0 && busy < 400) begin
            tick(1);
            busy++;
        end
        if (busy >= 400) mismatches++;
    endtask
    task automatic convert(input logic [3:0] c, input logic r, input logic l, input logic [3:0] later);
        chan = c;
        rsel = r;
        left = l;
        st_wr = 1'b1;
        tick(1);
        st_wr = 1'b0;
        `CHECK("start bit", 1'b1, st_bit)
        tick(6);
        chan = later;
        wait_idle();
        `CHECK("done flag", 1'b1, flag)
        `CHECK("mux resumed", later, channel_select)
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        `CHECK("flag cleared", 1'b0, flag)
    endtask
    task automatic check_result(input logic [3:0] c, input logic r, input logic l);
        `CHECK("result bytes", word(c, r, l), {r_hi, r_lo})
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // The longest path is well under a few thousand cycles; this only catches a hang.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    ////////////////////////////////////////
    initial begin
        tick(8);
        nrst_i = 1'b1;
        en = 1'b1;
        tick(1);
        convert(4'h3, 1'b0, 1'b0, 4'h3);
        `CHECK("first length", 1'b1, busy >= 48 && busy <= 55)
        check_result(4'h3, 1'b0, 1'b0);
        convert(4'hA, 1'b0, 1'b0, 4'hF);
        check_result(4'hF, 1'b0, 1'b0);
        for (int i = 0; i < 11; i++) begin
            ch = (i < 9) ? 4'(i) : (i == 9 ? 4'hE : 4'hF);
            convert(ch, i[0], i[1], ch);
            `CHECK("normal length", 1'b1, busy >= 24 && busy <= 31)
            check_result(ch, i[0], i[1]);
        end
        convert(4'h2, 1'b0, 1'b0, 4'h5);
        check_result(4'h2, 1'b0, 1'b0);
        lo_rd = 1'b1;
        tick(1);
        lo_rd = 1'b0;
        convert(4'h7, 1'b0, 1'b0, 4'h7);
        check_result(4'h2, 1'b0, 1'b0);
        hi_rd = 1'b1;
        tick(1);
        hi_rd = 1'b0;
        convert(4'h7, 1'b0, 1'b0, 4'h7);
        check_result(4'h7, 1'b0, 1'b0);
        auto_en = 1'b1;
        tsel = 3'h1;
        tick(2);
        trig[1] = 1'b1;
        tick(5);
        `CHECK("trigger start", 1'b1, st_bit)
        trig[1] = 1'b0;
        tick(3);
        trig[1] = 1'b1;
        wait_idle();
        tick(60);
        `CHECK("no retrigger", 1'b0, st_bit)
        `CHECK("trigger flag", 1'b1, flag)
        check_result(4'h7, 1'b0, 1'b0);
        convert(4'h4, 1'b1, 1'b0, 4'h4);
        convert(4'h1, 1'b0, 1'b0, 4'h1);
        tsel = 3'h0;
        st_wr = 1'b1;
        tick(1);
        st_wr = 1'b0;
        tick(20);
        chan = 4'h6;
        busy = 0;
        while ({r_hi, r_lo} !== word(4'h6, 1'b0, 1'b0) && busy < 300) begin
            tick(1);
            busy++;
        end
        `CHECK("chained result", 1'b1, busy < 300)
        `CHECK("start held", 1'b1, st_bit)
        auto_en = 1'b0;
        wait_idle();
        pwr_off = 1'b1;
        tick(2);
        `CHECK("analog off", 1'b0, ana_en)
        st_wr = 1'b1;
        tick(1);
        st_wr = 1'b0;
        tick(2);
        `CHECK("start refused", 1'b0, st_bit)
        pwr_off = 1'b0;
        tick(1);
        convert(4'h0, 1'b1, 1'b1, 4'h0);
        `CHECK("first again", 1'b1, busy >= 48 && busy <= 55)
        check_result(4'h0, 1'b1, 1'b1);
        psel = 3'h2;
        convert(4'h5, 1'b0, 1'b1, 4'h5);
        `CHECK("divide by four", 1'b1, busy >= 50 && busy <= 59)
        complete_run();
    end
endmodule
`default_nettype wire
